//--- ppx_host.sv
`timescale 1ns/1ps
// outside controller: cable-side peripheral engine for the ecp link
// plus an isa-side sequencer that runs epp data cycles
module ppx_host
    import ppx_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC,
    parameter int STROBE = STROBE_CYC,
    parameter int GAP    = GAP_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    // cable pins seen from the peripheral
    input  wire logic        host_clk,
    input  wire logic        host_ack,
    input  wire logic        reverse_req_n,
    input  wire logic [7:0]  pd_i,
    output logic      [7:0]  pd_o,
    output logic             pd_oe,
    output logic             periph_ack,
    output logic             periph_clk,
    output logic             periph_req_n,
    // peripheral user side
    output logic      [7:0]  rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic        want_reverse,
    // isa bus pins seen from the bus master
    output logic      [15:0] isa_addr,
    output logic             iow_n,
    output logic             ior_n,
    output logic      [7:0]  sd_o,
    output logic             sd_oe,
    input  wire logic [7:0]  sd_i,
    input  wire logic        iochrdy,
    // epp request side
    input  wire logic        epp_go,
    input  wire logic        epp_read,
    input  wire logic [7:0]  epp_wdata,
    output logic      [7:0]  epp_rdata,
    output logic             epp_done
);
    typedef enum logic [2:0] {
        PPX_FIDLE, PPX_FACK, PPX_FHAND, PPX_RSETUP, PPX_RWAITH, PPX_RWAITL
    } ppx_link_t;
    typedef enum logic [2:0] {
        PPX_IIDLE, PPX_IDIR, PPX_IGAP, PPX_ICYC, PPX_IREL
    } ppx_isa_t;

    localparam int CW = $clog2(STROBE + GAP + 2);

    ppx_link_t  link;
    ppx_isa_t   isa;
    logic [7:0] pd_s;
    logic       hclk_s;
    logic       hack_s;
    logic       rev_s;
    logic       rdy_s;
    logic       hclk_d;
    logic [CW-1:0] cnt;
    logic       cur_read;
    logic [7:0] cur_wdata;

    // cable pins settle before any use; data shares the same delay so
    // a byte set up before the strobe edge is still valid when seen
    ppx_sync #(.W(11), .SETTLE(SETTLE), .INIT(11'h700)) u_cable (
        .mclk (mclk),
        .rst  (rst),
        .din  ({host_clk, host_ack, reverse_req_n, pd_i}),
        .dout ({hclk_s, hack_s, rev_s, pd_s})
    );
    ppx_sync #(.W(1), .SETTLE(1), .INIT(1'b1)) u_rdy (
        .mclk (mclk),
        .rst  (rst),
        .din  (iochrdy),
        .dout (rdy_s)
    );

    // link decoding
    wire hclk_fall  = hclk_d & ~hclk_s;
    wire rev_active = ~rev_s;
    wire cnt_zero   = (cnt == '0);
    wire [7:0] dir_ctrl = epp_read ? (CTRL_RESET | 8'(1 << DIR_BIT))
                                   : (CTRL_RESET & ~8'(1 << DIR_BIT));

    // request line is free of the handshake, driven whenever asked
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            periph_req_n <= 1'b1;
            hclk_d       <= 1'b1;
        end else begin
            periph_req_n <= ~want_reverse;
            hclk_d       <= hclk_s;
        end
    end

    // ecp link engine; reset lands in forward idle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link       <= PPX_FIDLE;
            periph_ack <= 1'b0;
            periph_clk <= 1'b1;
            pd_o       <= 8'h00;
            pd_oe      <= 1'b0;
            rx_data    <= 8'h00;
            rx_valid   <= 1'b0;
            tx_ready   <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            tx_ready <= 1'b0;
            case (link)
                PPX_FIDLE: begin
                    periph_clk <= 1'b1;
                    periph_ack <= ~rx_ready;
                    if (~periph_ack && hclk_fall) begin
                        rx_data    <= pd_s;
                        periph_ack <= 1'b1;
                        link       <= PPX_FACK;
                    end else if (rev_active && hclk_s && ~hack_s
                                 && tx_valid) begin
                        pd_o  <= tx_data;
                        pd_oe <= 1'b1;
                        link  <= PPX_RSETUP;
                    end
                end
                PPX_FACK: begin
                    if (hclk_s) begin
                        rx_valid <= 1'b1;
                        link     <= PPX_FHAND;
                    end
                end
                PPX_FHAND: begin
                    if (rx_ready) begin
                        periph_ack <= 1'b0;
                        link       <= PPX_FIDLE;
                    end
                end
                PPX_RSETUP: begin
                    // data was driven one clock earlier for setup
                    periph_clk <= 1'b0;
                    link       <= PPX_RWAITH;
                end
                PPX_RWAITH: begin
                    if (hack_s) begin
                        periph_clk <= 1'b1;
                        tx_ready   <= 1'b1;
                        link       <= PPX_RWAITL;
                    end
                end
                PPX_RWAITL: begin
                    if (~hack_s) begin
                        pd_oe <= 1'b0;
                        link  <= PPX_FIDLE;
                    end
                end
                default: begin
                    link <= PPX_FIDLE;
                end
            endcase
        end
    end

    // isa sequencer: direction bit write, gap, then the epp cycle;
    // there is no timeout here, a peripheral that never releases the
    // wait line stalls the sequencer, as it would stall the bus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            isa       <= PPX_IIDLE;
            isa_addr  <= BASE_ADDR;
            iow_n     <= 1'b1;
            ior_n     <= 1'b1;
            sd_o      <= 8'h00;
            sd_oe     <= 1'b0;
            cnt       <= '0;
            cur_read  <= 1'b0;
            cur_wdata <= 8'h00;
            epp_rdata <= 8'h00;
            epp_done  <= 1'b0;
        end else begin
            epp_done <= 1'b0;
            if (!cnt_zero) begin
                cnt <= cnt - CW'(1);
            end
            case (isa)
                PPX_IIDLE: begin
                    if (epp_go) begin
                        cur_read  <= epp_read;
                        cur_wdata <= epp_wdata;
                        isa_addr  <= BASE_ADDR + CTRL_OFS;
                        sd_o      <= dir_ctrl;
                        sd_oe     <= 1'b1;
                        iow_n     <= 1'b0;
                        cnt       <= CW'(STROBE);
                        isa       <= PPX_IDIR;
                    end
                end
                PPX_IDIR: begin
                    if (cnt_zero) begin
                        iow_n <= 1'b1;
                        cnt   <= CW'(GAP);
                        isa   <= PPX_IGAP;
                    end
                end
                PPX_IGAP: begin
                    if (cnt_zero) begin
                        isa_addr <= BASE_ADDR + EPP_DATA_OFS;
                        sd_o     <= cur_wdata;
                        sd_oe    <= ~cur_read;
                        iow_n    <= cur_read;
                        ior_n    <= ~cur_read;
                        cnt      <= CW'(STROBE);
                        isa      <= PPX_ICYC;
                    end
                end
                PPX_ICYC: begin
                    // strobe stays low while the port holds ready low
                    if (cnt_zero && rdy_s) begin
                        epp_rdata <= sd_i;
                        iow_n     <= 1'b1;
                        ior_n     <= 1'b1;
                        cnt       <= CW'(GAP);
                        isa       <= PPX_IREL;
                    end
                end
                PPX_IREL: begin
                    sd_oe <= 1'b0;
                    if (cnt_zero) begin
                        epp_done <= 1'b1;
                        isa_addr <= BASE_ADDR;
                        isa      <= PPX_IIDLE;
                    end
                end
                default: begin
                    isa <= PPX_IIDLE;
                end
            endcase
        end
    end
endmodule : ppx_host

//--- ppx_pkg.sv
// Overview of operation
// - Forward idle: strobe high, busy low
// - Forward transfer from idle, interlocked handshake
// - Busy low before host lowers strobe
// - Data stable; busy rises answering strobe fall
// - Strobe high, byte taken, busy low
// - Reverse request asserted any time, asynchronously
// - Reverse idle: nack high, host ack low
// - Host ack low, then nack low with data
// - Host ack high, then nack returns high
// - Clear direction bit before an EPP write
// - Set direction bit before an EPP read
package ppx_pkg;
    // clock and derived counts
    localparam int CLK_HZ        = 40_000_000;
    localparam int CLK_PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);
    // input settle filter on cable pins
    localparam int SETTLE_NS     = 50;
    localparam int SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    // i/o strobe width and gap between bus cycles
    localparam int STROBE_NS     = 100;
    localparam int STROBE_CYC    = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    localparam int GAP_NS        = 100;
    localparam int GAP_CYC       = (GAP_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    // port register map relative to the port base
    localparam logic [15:0] BASE_ADDR    = 16'h0378;
    localparam logic [15:0] CTRL_OFS     = 16'h0002;
    localparam logic [15:0] EPP_DATA_OFS = 16'h0004;
    localparam int          DIR_BIT      = 5;
    localparam logic [7:0]  CTRL_RESET   = 8'h04;
endpackage : ppx_pkg

//--- ppx_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser followed by a settle filter per bit
module ppx_sync
    import ppx_pkg::*;
#(
    parameter int         W      = 1,
    parameter int         SETTLE = 2,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    localparam int CW = $clog2(SETTLE + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE);

    logic [W-1:0] meta;
    logic [W-1:0] sync;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= INIT;
            sync <= INIT;
        end else begin
            meta <= din;
            sync <= meta;
        end
    end

    // a bit is believed only after it stays put for the settle time
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [CW-1:0] cnt;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    cnt     <= '0;
                    dout[i] <= INIT[i];
                end else if (sync[i] == dout[i]) begin
                    cnt <= '0;
                end else if (cnt == LAST - CW'(1)) begin
                    cnt     <= '0;
                    dout[i] <= sync[i];
                end else begin
                    cnt <= cnt + CW'(1);
                end
            end
        end
    endgenerate
endmodule : ppx_sync

//--- ppx_host_chk.sv
`timescale 1ns/1ps
// watches the cable handshakes and the isa strobes of the controller
module ppx_host_chk
    import ppx_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        host_clk,
    input wire logic        host_ack,
    input wire logic        pd_oe,
    input wire logic        periph_ack,
    input wire logic        periph_clk,
    input wire logic [15:0] isa_addr,
    input wire logic        iow_n,
    input wire logic        ior_n,
    input wire logic        iochrdy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // windows allow two sync flops, the settle filter and one register
    a_fwd_ack_bound: assert property (
        $fell(host_clk) && !periph_ack |-> ##[3:7] periph_ack)
        else $error("busy did not answer the strobe");
    // the far side may answer in the very cycle busy is first seen high,
    // so the cause is looked for one cycle back
    a_ack_rise_cause: assert property (
        $rose(periph_ack) |-> !$past(host_clk))
        else $error("busy rose without a strobe");
    a_ack_drop_cause: assert property (
        $fell(periph_ack) |-> host_clk)
        else $error("busy fell while strobe low");
    a_fwd_release: assert property (
        $rose(host_clk) && periph_ack |-> ##[3:8] !periph_ack)
        else $error("busy stuck after strobe release");
    a_rev_data_first: assert property (
        $fell(periph_clk) |-> pd_oe && $past(pd_oe) && !host_ack)
        else $error("reverse clock fell before data");
    a_rev_clk_back: assert property (
        $rose(periph_clk) |-> $past(host_ack))
        else $error("reverse clock rose without ack");
    a_rev_clk_bound: assert property (
        $rose(host_ack) && !periph_clk |-> ##[3:7] periph_clk)
        else $error("reverse clock did not return");
    a_rev_end: assert property (
        $fell(host_ack) && pd_oe |-> ##[3:7] !pd_oe)
        else $error("data not released after ack");
    // the epp strobe must not move while the port holds ready low
    a_epp_ready_hold: assert property (
        !(iow_n && ior_n) && isa_addr == BASE_ADDR + EPP_DATA_OFS
        && !iochrdy |=> $stable({iow_n, ior_n}))
        else $error("strobe released while not ready");
endmodule : ppx_host_chk

bind ppx_host ppx_host_chk i_ppx_host_chk (
    .mclk(mclk), .rst(rst), .host_clk(host_clk), .host_ack(host_ack),
    .pd_oe(pd_oe), .periph_ack(periph_ack), .periph_clk(periph_clk),
    .isa_addr(isa_addr), .iow_n(iow_n), .ior_n(ior_n), .iochrdy(iochrdy)
);

//--- ppx_port_model.sv
`timescale 1ns/1ps
// behavioural port chip: host side of the cable and isa target
module ppx_port_model
    import ppx_pkg::*;
#(
    parameter int WAIT = 10
) (
    input  wire logic        mclk,
    input  wire logic        periph_ack,
    input  wire logic        periph_clk,
    input  wire logic [7:0]  pd_o,
    output logic             host_clk,
    output logic             host_ack,
    output logic             reverse_req_n,
    output logic      [7:0]  pd_i,
    input  wire logic [15:0] isa_addr,
    input  wire logic        iow_n,
    input  wire logic        ior_n,
    input  wire logic [7:0]  sd_o,
    output logic      [7:0]  sd_i,
    output logic             iochrdy
);
    logic [7:0] ctrl;
    logic [7:0] wdata;
    int         cnt = 0;
    // idle levels from power-up
    initial begin
        host_clk = 1'b1;
        host_ack = 1'b0;
        reverse_req_n = 1'b1;
        pd_i = 8'h00;
        iochrdy = 1'b1;
    end
    // released bus shows the inverse so a stale value never matches
    assign sd_i = ior_n ? 8'hC3 : 8'h3C;
    // the leading negedge keeps pd_i from moving twice in one step
    // between calls; pacing looks at busy only, never at the ack line
    task automatic send(input logic [7:0] d);
        @(negedge mclk);
        while (periph_ack !== 1'b0) @(negedge mclk);
        pd_i = d;
        @(negedge mclk);
        host_clk = 1'b0;
        while (periph_ack !== 1'b1) @(negedge mclk);
        host_clk = 1'b1;
        while (periph_ack !== 1'b0) @(negedge mclk);
        pd_i = ~d;
    endtask : send
    task automatic recv(output logic [7:0] d);
        reverse_req_n = 1'b0;
        while (periph_clk !== 1'b0) @(negedge mclk);
        reverse_req_n = 1'b1;
        d = pd_o;
        @(negedge mclk);
        host_ack = 1'b1;
        while (periph_clk !== 1'b1) @(negedge mclk);
        host_ack = 1'b0;
    endtask : recv
    // ready is held low for the first WAIT cycles of the epp data strobe;
    // this stands for the port waiting on its wait line while it strobes
    always @(negedge mclk) begin
        if (!(iow_n && ior_n) && isa_addr == BASE_ADDR + EPP_DATA_OFS)
            cnt = cnt + 1;
        else
            cnt = 0;
        iochrdy = (cnt == 0 || cnt > WAIT);
    end
    // writes land at the end of the strobe; the port's write line would
    // be low only inside that data strobe
    always @(posedge iow_n) begin
        if (isa_addr == BASE_ADDR + CTRL_OFS) ctrl = sd_o;
        if (isa_addr == BASE_ADDR + EPP_DATA_OFS) wdata = sd_o;
    end
endmodule : ppx_port_model

//--- ppx_host_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the outside controller
module ppx_host_tb_top
    import ppx_pkg::*;
;
    logic        mclk, rst, host_clk, host_ack, reverse_req_n, pd_oe;
    logic        periph_ack, periph_clk, periph_req_n, rx_valid, rx_ready;
    logic        tx_valid, tx_ready, want_reverse, iow_n, ior_n, sd_oe;
    logic        iochrdy, epp_go, epp_read, epp_done;
    logic [7:0]  pd_i, pd_o, rx_data, tx_data, sd_o, sd_i, got;
    logic [7:0]  epp_wdata, epp_rdata;
    logic [15:0] isa_addr;
    logic [7:0]  rxq[$];
    int          bad_count, check_count, cyc, tx_count;
    // one byte in 2 us keeps pace with the peak forward rate
    localparam int FWD_BYTE_CYC = CLK_HZ / 500_000;

    ppx_host i_ppx_host (
        .mclk(mclk), .rst(rst), .host_clk(host_clk), .host_ack(host_ack),
        .reverse_req_n(reverse_req_n), .pd_i(pd_i), .pd_o(pd_o),
        .pd_oe(pd_oe), .periph_ack(periph_ack), .periph_clk(periph_clk),
        .periph_req_n(periph_req_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready),
        .want_reverse(want_reverse), .isa_addr(isa_addr), .iow_n(iow_n),
        .ior_n(ior_n), .sd_o(sd_o), .sd_oe(sd_oe), .sd_i(sd_i),
        .iochrdy(iochrdy), .epp_go(epp_go), .epp_read(epp_read),
        .epp_wdata(epp_wdata), .epp_rdata(epp_rdata), .epp_done(epp_done)
    );
    ppx_port_model i_ppx_port_model (
        .mclk(mclk), .periph_ack(periph_ack), .periph_clk(periph_clk),
        .pd_o(pd_o), .host_clk(host_clk), .host_ack(host_ack),
        .reverse_req_n(reverse_req_n), .pd_i(pd_i), .isa_addr(isa_addr),
        .iow_n(iow_n), .ior_n(ior_n), .sd_o(sd_o), .sd_i(sd_i),
        .iochrdy(iochrdy)
    );
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // collect forward bytes and reverse accepts where they have settled;
    // each pulse stands one cycle only
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (tx_ready === 1'b1) tx_count++;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic t_reset;
        rst = 1'b1;
        repeat (8) @(negedge mclk);
        check(periph_clk, 1'b1);
        check(periph_ack, 1'b0);
        check({pd_oe, iow_n, ior_n}, 3'b011);
        check(isa_addr, BASE_ADDR);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        $display("reset test done");
    endtask : t_reset
    task automatic t_fwd;
        logic [7:0] v[4] = '{8'h5A, 8'hA5, 8'h00, 8'hFF};
        int         t0;
        t0 = cyc;
        foreach (v[i]) i_ppx_port_model.send(v[i]);
        check(16'(cyc - t0 <= 4 * FWD_BYTE_CYC), 16'd1);
        repeat (8) @(negedge mclk);
        check(16'(rxq.size()), 16'd4);
        foreach (v[i]) check(rxq[i], v[i]);
        rxq.delete();
        $display("forward test done");
    endtask : t_fwd
    task automatic t_rev;
        want_reverse = 1'b1;
        repeat (2) @(negedge mclk);
        check(periph_req_n, 1'b0);
        want_reverse = 1'b0;
        repeat (2) @(negedge mclk);
        check(periph_req_n, 1'b1);
        for (int i = 0; i < 2; i++) begin
            tx_data = i ? 8'h3C : 8'hC3;
            tx_valid = 1'b1;
            i_ppx_port_model.recv(got);
            tx_valid = 1'b0;
            check(got, tx_data);
            repeat (8) @(negedge mclk);
            check({pd_oe, periph_clk}, 2'b01);
            check(16'(tx_count), 16'(i + 1));
        end
        $display("reverse test done");
    endtask : t_rev
    task automatic t_epp;
        for (int rd = 0; rd < 2; rd++) begin
            epp_read = rd[0];
            epp_go = 1'b1;
            @(negedge mclk);
            epp_go = 1'b0;
            for (int n = 0; n < 200 && epp_done !== 1'b1; n++)
                @(negedge mclk);
            check(epp_done, 1'b1);
            check({sd_oe, iow_n, ior_n}, 3'b011);
            check(i_ppx_port_model.ctrl,
                  CTRL_RESET | 8'(rd << DIR_BIT));
            if (rd) check(epp_rdata, 8'h3C);
            else check(i_ppx_port_model.wdata, 8'h96);
            repeat (GAP_CYC + 2) @(negedge mclk);
        end
        $display("epp test done");
    endtask : t_epp
    // second reset lands in the middle of a bus sequence
    initial begin
        {rst, rx_ready, tx_valid, want_reverse, epp_go} = 5'b11000;
        {tx_data, epp_wdata, epp_read} = {8'h00, 8'h96, 1'b0};
        t_reset();
        t_fwd();
        t_rev();
        t_epp();
        epp_go = 1'b1;
        repeat (6) @(negedge mclk);
        epp_go = 1'b0;
        t_reset();
        t_fwd();
        print_verdict();
    end
endmodule : ppx_host_tb_top
